/* inc/tmcac_defines.svh */
// register indices, field positions and reset values of the channel control block
`ifndef TMCAC_DEFINES_SVH
`define TMCAC_DEFINES_SVH

// register indices; byte address is four times the index
`define TMCAC_IDX_COMPARE_SELECT 6'h00
`define TMCAC_IDX_FORCE_COMPARE 6'h01
`define TMCAC_IDX_CH7_MASK 6'h02
`define TMCAC_IDX_CH7_DATA 6'h03
`define TMCAC_IDX_OVF_TOGGLE 6'h07
`define TMCAC_IDX_ACTION_UPPER 6'h08
`define TMCAC_IDX_ACTION_LOWER 6'h09
`define TMCAC_IDX_EDGE_UPPER 6'h0a
`define TMCAC_IDX_EDGE_LOWER 6'h0b
`define TMCAC_IDX_IRQ_ENABLE 6'h0c
`define TMCAC_IDX_EVENT_FLAGS 6'h0e
`define TMCAC_IDX_PIN_DISCONNECT 6'h2c

// bus field positions
`define TMCAC_ADDR_IDX_MSB 7
`define TMCAC_ADDR_IDX_LSB 2
`define TMCAC_HTRANS_ACTIVE_BIT 1

// reset values
`define TMCAC_RESET_BYTE 8'h00
`define TMCAC_RESET_PAIRS 16'h0000
`define TMCAC_RESET_WORD 32'h0000_0000

`endif

/* inc/tmcac_pkg.sv */
// types shared by the timer channel control block
package tmcac_pkg;

    typedef enum logic [1:0] {
        TMCAC_ACT_NONE = 2'b00,
        TMCAC_ACT_TOGGLE = 2'b01,
        TMCAC_ACT_CLEAR = 2'b10,
        TMCAC_ACT_SET = 2'b11
    } tmcac_action_type;

    typedef enum logic [1:0] {
        TMCAC_EDGE_OFF = 2'b00,
        TMCAC_EDGE_RISE = 2'b01,
        TMCAC_EDGE_FALL = 2'b10,
        TMCAC_EDGE_ANY = 2'b11
    } tmcac_edge_type;

    typedef enum logic {
        TMCAC_BUS_IDLE = 1'b0,
        TMCAC_BUS_READ = 1'b1
    } tmcac_bus_state_type;

endpackage

/* src/tmcac_channel_ctrl.sv */
// output compare action, capture edge and channel event control for eight timer channels
//
// What this block does
// - overflow toggles pin when enabled in compare mode
// - ch7 override beats overflow toggle beats forced
// - mode/level pair: none, toggle, clear, set
// - nonzero mode/level makes a compare-mode pin an output
// - own action reaches pin only if unmasked
// - pin driven only while disconnect bit clear
// - masked channel 7 takes its data bit
// - ch7 compare drives data bit on masked compare-mode channels
// - edge pair: off, rising, falling, any edge
// - enable bit gates matching event flag interrupt
// - capture or compare event sets channel flag
// - overflow means counter wraps ffff to 0000
`timescale 1ns/1ns
`default_nettype none
`include "tmcac_defines.svh"

module tmcac_channel_ctrl
    import tmcac_pkg::*;
#(
    parameter int CHANNELS = 8
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic counterWrap,
    input wire logic [7:0] compareMatch,
    input wire logic [7:0] channelPinIn,
    output logic [7:0] channelPinOut,
    output logic [7:0] channelPinOe,
    output logic [7:0] captureStrobe,
    output logic channelIrq
);

    ////////////////////////////////////////////////////////////////////////////////
    // the register layout packs eight channels per byte, four per byte in the action and edge pair registers
    if (CHANNELS != 8) begin : gBadChannels
        $error("tmcac_channel_ctrl supports exactly eight channels");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // state
    logic [7:0] compareSelect_q, compareSelect_d;
    logic [7:0] ch7Mask_q, ch7Mask_d;
    logic [7:0] ch7Data_q, ch7Data_d;
    logic [7:0] ovfToggle_q, ovfToggle_d;
    logic [15:0] action_q, action_d;
    logic [15:0] edgeSel_q, edgeSel_d;
    logic [7:0] irqEnable_q, irqEnable_d;
    logic [7:0] eventFlags_q, eventFlags_d;
    logic [7:0] pinDisconnect_q, pinDisconnect_d;
    logic [7:0] pinOut_q, pinOut_d;
    logic [7:0] pinOe_q, pinOe_d;
    logic [7:0] capture_q, capture_d;
    logic irq_q, irq_d;
    logic [7:0] pinMeta_q;
    logic [7:0] pinSync_q;
    logic [7:0] pinPrev_q;
    tmcac_bus_state_type busState_q, busState_d;
    logic wrPend_q, wrPend_d;
    logic [5:0] wrIdx_q, wrIdx_d;
    logic [5:0] rdIdx_q, rdIdx_d;
    logic ready_q, ready_d;
    logic resp_q;
    logic [31:0] rdata_q, rdata_d;

    logic addrTaken;
    logic [5:0] addrIdx;
    logic [7:0] wbyte;
    logic [7:0] forceNow;
    logic ch7Event;
    logic [7:0] pinNext;
    logic [7:0] oeNext;
    logic [7:0] eventNow;
    logic [7:0] captureNow;

    ////////////////////////////////////////////////////////////////////////////////
    // bus decode
    assign addrTaken = hsel && htrans[`TMCAC_HTRANS_ACTIVE_BIT] && hready;
    assign addrIdx = haddr[`TMCAC_ADDR_IDX_MSB:`TMCAC_ADDR_IDX_LSB];
    assign wbyte = hwdata[7:0];
    // force is a write-only strobe, acting in the write data phase
    assign forceNow = (wrPend_q && wrIdx_q == `TMCAC_IDX_FORCE_COMPARE) ? wbyte
        : `TMCAC_RESET_BYTE;
    // ch7 events act on other channels only when ch7 itself is in compare mode
    assign ch7Event = compareSelect_q[7] && (compareMatch[7] || forceNow[7]);

    function automatic logic [7:0] readMux(input logic [5:0] idx);
        logic [7:0] v;
        v = `TMCAC_RESET_BYTE;
        case (idx)
            `TMCAC_IDX_COMPARE_SELECT: v = compareSelect_q;
            `TMCAC_IDX_CH7_MASK: v = ch7Mask_q;
            `TMCAC_IDX_CH7_DATA: v = ch7Data_q;
            `TMCAC_IDX_OVF_TOGGLE: v = ovfToggle_q;
            `TMCAC_IDX_ACTION_UPPER: v = action_q[15:8];
            `TMCAC_IDX_ACTION_LOWER: v = action_q[7:0];
            `TMCAC_IDX_EDGE_UPPER: v = edgeSel_q[15:8];
            `TMCAC_IDX_EDGE_LOWER: v = edgeSel_q[7:0];
            `TMCAC_IDX_IRQ_ENABLE: v = irqEnable_q;
            `TMCAC_IDX_EVENT_FLAGS: v = eventFlags_q;
            `TMCAC_IDX_PIN_DISCONNECT: v = pinDisconnect_q;
            default: v = `TMCAC_RESET_BYTE;
        endcase
        return v;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // per channel pin and event logic
    for (genvar i = 0; i < 8; i++) begin : gChan
        tmcac_action_type act;
        tmcac_edge_type edgeMode;
        logic ch7Hit;
        logic ovfHit;
        logic ownFire;
        logic rise;
        logic fall;

        assign act = tmcac_action_type'(action_q[2*i+1:2*i]);
        assign edgeMode = tmcac_edge_type'(edgeSel_q[2*i+1:2*i]);
        assign ch7Hit = ch7Event && ch7Mask_q[i] && compareSelect_q[i];
        // counterWrap marks the ffff to 0000 step of the main counter
        assign ovfHit = counterWrap && ovfToggle_q[i] && compareSelect_q[i];
        // masked channels leave their own action off the pin
        assign ownFire = compareSelect_q[i] && !ch7Mask_q[i]
            && (compareMatch[i] || forceNow[i]);

        always_comb begin
            pinNext[i] = pinOut_q[i];
            if (ch7Hit) begin
                pinNext[i] = ch7Data_q[i];
            end else if (ovfHit) begin
                pinNext[i] = !pinOut_q[i];
            end else if (ownFire) begin
                case (act)
                    TMCAC_ACT_NONE: pinNext[i] = pinOut_q[i];
                    TMCAC_ACT_TOGGLE: pinNext[i] = !pinOut_q[i];
                    TMCAC_ACT_CLEAR: pinNext[i] = 1'b0;
                    TMCAC_ACT_SET: pinNext[i] = 1'b1;
                    default: pinNext[i] = pinOut_q[i];
                endcase
            end
        end

        // pin becomes an output once any compare source may drive it
        assign oeNext[i] = compareSelect_q[i] && !pinDisconnect_q[i]
            && (act != TMCAC_ACT_NONE || ch7Mask_q[i] || ovfToggle_q[i]);

        assign rise = pinSync_q[i] && !pinPrev_q[i];
        assign fall = !pinSync_q[i] && pinPrev_q[i];
        assign captureNow[i] = !compareSelect_q[i]
            && ((edgeMode[0] && rise) || (edgeMode[1] && fall));
        // forced compares move the pin but raise no flag
        assign eventNow[i] = captureNow[i]
            || (compareSelect_q[i] && compareMatch[i]);
    end

    ////////////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        compareSelect_d = compareSelect_q;
        ch7Mask_d = ch7Mask_q;
        ch7Data_d = ch7Data_q;
        ovfToggle_d = ovfToggle_q;
        action_d = action_q;
        edgeSel_d = edgeSel_q;
        irqEnable_d = irqEnable_q;
        pinDisconnect_d = pinDisconnect_q;
        eventFlags_d = eventFlags_q;
        busState_d = busState_q;
        wrPend_d = 1'b0;
        wrIdx_d = wrIdx_q;
        rdIdx_d = rdIdx_q;
        ready_d = ready_q;
        rdata_d = rdata_q;

        if (wrPend_q) begin
            case (wrIdx_q)
                `TMCAC_IDX_COMPARE_SELECT: compareSelect_d = wbyte;
                `TMCAC_IDX_CH7_MASK: ch7Mask_d = wbyte;
                `TMCAC_IDX_CH7_DATA: ch7Data_d = wbyte;
                `TMCAC_IDX_OVF_TOGGLE: ovfToggle_d = wbyte;
                `TMCAC_IDX_ACTION_UPPER: action_d[15:8] = wbyte;
                `TMCAC_IDX_ACTION_LOWER: action_d[7:0] = wbyte;
                `TMCAC_IDX_EDGE_UPPER: edgeSel_d[15:8] = wbyte;
                `TMCAC_IDX_EDGE_LOWER: edgeSel_d[7:0] = wbyte;
                `TMCAC_IDX_IRQ_ENABLE: irqEnable_d = wbyte;
                `TMCAC_IDX_EVENT_FLAGS: eventFlags_d = eventFlags_q & ~wbyte;
                `TMCAC_IDX_PIN_DISCONNECT: pinDisconnect_d = wbyte;
                default: ;
            endcase
        end
        // a new event wins over a clear in the same cycle
        eventFlags_d = eventFlags_d | eventNow;

        case (busState_q)
            TMCAC_BUS_IDLE: begin
                if (addrTaken && hwrite) begin
                    wrPend_d = 1'b1;
                    wrIdx_d = addrIdx;
                end else if (addrTaken) begin
                    // one wait state so a read always sees completed writes
                    rdIdx_d = addrIdx;
                    ready_d = 1'b0;
                    busState_d = TMCAC_BUS_READ;
                end
            end
            TMCAC_BUS_READ: begin
                rdata_d = {24'h00_0000, readMux(rdIdx_q)};
                ready_d = 1'b1;
                busState_d = TMCAC_BUS_IDLE;
            end
            default: begin
                ready_d = 1'b1;
                busState_d = TMCAC_BUS_IDLE;
            end
        endcase

        pinOut_d = pinNext;
        pinOe_d = oeNext;
        capture_d = captureNow;
        irq_d = |(eventFlags_d & irqEnable_d);
    end

    ////////////////////////////////////////////////////////////////////////////////
    // registers
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            compareSelect_q <= `TMCAC_RESET_BYTE;
            ch7Mask_q <= `TMCAC_RESET_BYTE;
            ch7Data_q <= `TMCAC_RESET_BYTE;
            ovfToggle_q <= `TMCAC_RESET_BYTE;
            action_q <= `TMCAC_RESET_PAIRS;
            edgeSel_q <= `TMCAC_RESET_PAIRS;
            irqEnable_q <= `TMCAC_RESET_BYTE;
            eventFlags_q <= `TMCAC_RESET_BYTE;
            pinDisconnect_q <= `TMCAC_RESET_BYTE;
            pinOut_q <= `TMCAC_RESET_BYTE;
            pinOe_q <= `TMCAC_RESET_BYTE;
            capture_q <= `TMCAC_RESET_BYTE;
            irq_q <= 1'b0;
            pinMeta_q <= `TMCAC_RESET_BYTE;
            pinSync_q <= `TMCAC_RESET_BYTE;
            pinPrev_q <= `TMCAC_RESET_BYTE;
            busState_q <= TMCAC_BUS_IDLE;
            wrPend_q <= 1'b0;
            wrIdx_q <= 6'h00;
            rdIdx_q <= 6'h00;
            ready_q <= 1'b1;
            resp_q <= 1'b0;
            rdata_q <= `TMCAC_RESET_WORD;
        end else begin
            compareSelect_q <= compareSelect_d;
            ch7Mask_q <= ch7Mask_d;
            ch7Data_q <= ch7Data_d;
            ovfToggle_q <= ovfToggle_d;
            action_q <= action_d;
            edgeSel_q <= edgeSel_d;
            irqEnable_q <= irqEnable_d;
            eventFlags_q <= eventFlags_d;
            pinDisconnect_q <= pinDisconnect_d;
            pinOut_q <= pinOut_d;
            pinOe_q <= pinOe_d;
            capture_q <= capture_d;
            irq_q <= irq_d;
            // pins come from outside: two stages before any edge logic
            pinMeta_q <= channelPinIn;
            pinSync_q <= pinMeta_q;
            pinPrev_q <= pinSync_q;
            busState_q <= busState_d;
            wrPend_q <= wrPend_d;
            wrIdx_q <= wrIdx_d;
            rdIdx_q <= rdIdx_d;
            ready_q <= ready_d;
            resp_q <= 1'b0;
            rdata_q <= rdata_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // outputs
    assign hreadyout = ready_q;
    assign hresp = resp_q;
    assign hrdata = rdata_q;
    assign channelPinOut = pinOut_q;
    assign channelPinOe = pinOe_q;
    assign captureStrobe = capture_q;
    assign channelIrq = irq_q;

endmodule

`default_nettype wire

/* test/tmcac_channel_ctrl_props.sv */
// checker of bus timing and channel event relations
`timescale 1ns/1ns
`default_nettype none
module tmcac_channel_ctrl_props #(
    parameter int CHANNELS = 8
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic counterWrap,
    input wire logic [7:0] compareMatch,
    input wire logic [7:0] channelPinOut,
    input wire logic [7:0] channelPinOe,
    input wire logic [7:0] captureStrobe,
    input wire logic channelIrq
);
    logic take;
    logic wrPhase_d;
    logic wrPhase_q;
    always_comb begin
        take = hsel & htrans[1] & hready;
        wrPhase_d = take & hwrite;
    end
    // write data phase marker: forced compares and config changes act there
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wrPhase_q <= 1'b0;
        end else begin
            wrPhase_q <= wrPhase_d;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    sequence readWait;
        !hreadyout ##1 hreadyout;
    endsequence
    ////////////////////////////////////////////////////////////////////////////////
    AST_READ_WAIT: assert property (take && !hwrite |=> readWait)
        else $error("read without its single wait state");
    AST_WRITE_NOWAIT: assert property (take && hwrite |=> hreadyout)
        else $error("write data phase stalled");
    AST_OKAY: assert property (hresp == 1'b0)
        else $error("response not okay");
    AST_PIN_CAUSE: assert property ($changed(channelPinOut) |->
        $past(compareMatch) != 8'h00 || $past(counterWrap) || $past(wrPhase_q))
        else $error("pin moved without compare, wrap or write");
    // config lands one edge after the data phase, the enable one edge later
    AST_OE_CAUSE: assert property ($changed(channelPinOe) |-> $past(wrPhase_q, 2))
        else $error("pin enable moved without write");
    AST_IRQ_RISE: assert property ($rose(channelIrq) |->
        $past(compareMatch) != 8'h00 || captureStrobe != 8'h00 || $past(wrPhase_q))
        else $error("interrupt rose without event");
    AST_IRQ_FALL: assert property ($fell(channelIrq) |-> $past(wrPhase_q))
        else $error("interrupt fell without write");
    AST_STROBE_PULSE: assert property (captureStrobe != 8'h00 |=> captureStrobe == 8'h00)
        else $error("capture strobe longer than one cycle");
    AST_STROBE_INPUT: assert property ((captureStrobe & channelPinOe) == 8'h00)
        else $error("capture on a driven pin");
endmodule
bind tmcac_channel_ctrl tmcac_channel_ctrl_props #(.CHANNELS(CHANNELS)) props (.clk(clk),
    .reset_n(reset_n), .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .counterWrap(counterWrap),
    .compareMatch(compareMatch), .channelPinOut(channelPinOut), .channelPinOe(channelPinOe),
    .captureStrobe(captureStrobe), .channelIrq(channelIrq));
`default_nettype wire

/* test/tmcac_pin_partner.sv */
// far-side pin model: resolves each channel pin from the block and an outside driver
`timescale 1ns/1ns
`default_nettype none
module tmcac_pin_partner (
    input wire logic [7:0] pinOut,
    input wire logic [7:0] pinOe,
    input wire logic [7:0] extLevel,
    output logic [7:0] pinLevel
);
    // block wins where it drives; outside level elsewhere, no pulls
    always_comb begin
        pinLevel = (pinOe & pinOut) | (~pinOe & extLevel);
    end
endmodule
`default_nettype wire

/* test/tmcac_channel_ctrl_tb.sv */
// self-checking bench: registers, compare actions, overflow, channel 7 and capture
`timescale 1ns/1ns
`default_nettype none
`include "tmcac_defines.svh"
module tmcac_channel_ctrl_tb
    import tmcac_pkg::*;
();
    logic clk = 1'b0;
    logic resetN = 1'b0;
    logic hsel = 1'b1;
    logic hwrite = 1'b0;
    logic counterWrap = 1'b0;
    logic [1:0] htrans = 2'b00;
    logic [2:0] hsize = 3'b010;
    logic [31:0] haddr = 32'h0000_0000;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [31:0] hrdata, rd;
    logic hreadyout, hresp, channelIrq;
    logic [7:0] compareMatch = 8'h00;
    logic [7:0] extLevel = 8'h00;
    logic [7:0] pinOut, pinOe, pinLevel, captureStrobe;
    logic [5:0] regIdx [6] = '{`TMCAC_IDX_OVF_TOGGLE, `TMCAC_IDX_EDGE_UPPER,
        `TMCAC_IDX_EDGE_LOWER, `TMCAC_IDX_IRQ_ENABLE, `TMCAC_IDX_ACTION_UPPER,
        `TMCAC_IDX_ACTION_LOWER};
    // strobes per mode: off, rising, falling, any
    logic [7:0] capCount [4] = '{8'h00, 8'h01, 8'h01, 8'h02};
    int mismatches = 0;
    int numChecks = 0;
    int strobes = 0;
    always #4 clk = ~clk;
    tmcac_channel_ctrl uut (.clk(clk), .reset_n(resetN), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .counterWrap(counterWrap),
        .compareMatch(compareMatch), .channelPinIn(pinLevel), .channelPinOut(pinOut),
        .channelPinOe(pinOe), .captureStrobe(captureStrobe), .channelIrq(channelIrq));
    tmcac_pin_partner partner (.pinOut(pinOut), .pinOe(pinOe), .extLevel(extLevel),
        .pinLevel(pinLevel));
    always @(posedge clk) begin
        if (captureStrobe[5] === 1'b1) begin
            strobes++;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        numChecks++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // no wait count assumed: the watchdog cuts a hung handshake
    task automatic access(input logic [5:0] idx, input logic wr, input logic [7:0] data);
        @(posedge clk);
        haddr <= {24'h000000, idx, 2'b00};
        hwrite <= wr;
        htrans <= 2'b10;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= {24'h000000, data};
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
        // one more edge so config-driven outputs have settled before a check
        @(posedge clk);
        #1;
    endtask
    task automatic rdChk(input logic [5:0] idx, input logic [7:0] exp);
        access(idx, 1'b0, 8'h00);
        check(rd[7:0], exp);
        check({7'h00, |rd[31:8]}, 8'h00);
        check({7'h00, hresp}, 8'h00);
    endtask
    task automatic pulse(input logic [7:0] m, input logic w);
        @(posedge clk);
        compareMatch <= m;
        counterWrap <= w;
        @(posedge clk);
        compareMatch <= 8'h00;
        counterWrap <= 1'b0;
        #1;
    endtask
    task automatic conclude();
        if (mismatches == 0 && numChecks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        #100000;
        mismatches++;
        conclude();
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(posedge clk);
        resetN <= 1'b1;
        foreach (regIdx[i]) rdChk(regIdx[i], 8'h00);
        foreach (regIdx[i]) access(regIdx[i], 1'b1, 8'h5a ^ 8'(i));
        foreach (regIdx[i]) rdChk(regIdx[i], 8'h5a ^ 8'(i));
        foreach (regIdx[i]) access(regIdx[i], 1'b1, 8'h00);
        access(6'h3f, 1'b1, 8'hff);
        rdChk(6'h3f, 8'h00);
        // ch0 none, ch1 toggle, ch2 clear, ch3 set; ch0 left free for the overflow toggle
        access(`TMCAC_IDX_COMPARE_SELECT, 1'b1, 8'h0f);
        access(`TMCAC_IDX_ACTION_LOWER, 1'b1,
            {TMCAC_ACT_SET, TMCAC_ACT_CLEAR, TMCAC_ACT_TOGGLE, TMCAC_ACT_NONE});
        check(pinOe, 8'h0e);
        pulse(8'h0f, 1'b0);
        check(pinOut, 8'h0a);
        pulse(8'h0f, 1'b0);
        check(pinOut, 8'h08);
        rdChk(`TMCAC_IDX_EVENT_FLAGS, 8'h0f);
        check({7'h00, channelIrq}, 8'h00);
        access(`TMCAC_IDX_IRQ_ENABLE, 1'b1, 8'h08);
        check({7'h00, channelIrq}, 8'h01);
        access(`TMCAC_IDX_EVENT_FLAGS, 1'b1, 8'h08);
        check({7'h00, channelIrq}, 8'h00);
        rdChk(`TMCAC_IDX_EVENT_FLAGS, 8'h07);
        // wrap and a clear compare on ch2 together: the toggle wins
        access(`TMCAC_IDX_OVF_TOGGLE, 1'b1, 8'h05);
        check(pinOe, 8'h0f);
        pulse(8'h04, 1'b1);
        check(pinOut, 8'h0d);
        pulse(8'h00, 1'b1);
        check(pinOut, 8'h08);
        access(`TMCAC_IDX_PIN_DISCONNECT, 1'b1, 8'h01);
        check(pinOe, 8'h0e);
        // ch4 and ch7 masked: ch7 compare drives the data bits
        access(`TMCAC_IDX_COMPARE_SELECT, 1'b1, 8'h9f);
        access(`TMCAC_IDX_ACTION_UPPER, 1'b1, {TMCAC_ACT_SET, 4'h0, TMCAC_ACT_CLEAR});
        access(`TMCAC_IDX_CH7_DATA, 1'b1, 8'h10);
        access(`TMCAC_IDX_CH7_MASK, 1'b1, 8'h90);
        check(pinOe, 8'h9e);
        pulse(8'h80, 1'b0);
        check(pinOut, 8'h18);
        access(`TMCAC_IDX_CH7_DATA, 1'b1, 8'h00);
        access(`TMCAC_IDX_CH7_MASK, 1'b1, 8'h10);
        pulse(8'h80, 1'b0);
        check(pinOut, 8'h88);
        // forced toggle on ch1 moves the pin; the strobe reads back zero
        access(`TMCAC_IDX_FORCE_COMPARE, 1'b1, 8'h02);
        check(pinOut, 8'h8a);
        rdChk(`TMCAC_IDX_FORCE_COMPARE, 8'h00);
        // capture on ch5, an input channel, in every edge mode
        for (int m = 0; m < 4; m++) begin
            access(`TMCAC_IDX_EDGE_UPPER, 1'b1, {4'h0, 2'(m), 2'b00});
            strobes = 0;
            @(posedge clk);
            extLevel <= 8'h20;
            repeat (8) @(posedge clk);
            extLevel <= 8'h00;
            repeat (8) @(posedge clk);
            check(8'(strobes), capCount[m]);
        end
        conclude();
    end
endmodule
`default_nettype wire
